// *** rtl/apc_port.sv ***
// What this block does
// - Reading the snapshot register returns the synchronised level of all eight pins.
// - Writes to the snapshot register change nothing.
// - A direction bit of 0 makes its pin an input and 1 an output.
// - After a direction change, data and snapshot reads may lag by up to two cycles.
// - A set weaken bit asks the pad for about one third drive, clear means full.
// - On an input pin the weaken bit has no effect on the pad.
// - A set pull enable turns on the pull device of its input pin, clear keeps it off.
// - On an output pin the pull enable never turns on a pull device.
// - Reset leaves every pull device off.
// - A pin whose converter channel is enabled never gets a pull device.
// - The polarity bit picks pull-up or pull-down only for an enabled input pin.
// - Every pin works as plain I/O or carries a peripheral's output or input.
// - Configuration registers store any write even when the setting cannot act.
// - Data reads give the latch where the direction bit is 1 and the pin level where it is 0.
// - A pin under peripheral control ignores its direction bit, except in data reads.
//
// Eight-pin port shared with converter channels, register port slave
// Assumes a one-cycle strobe master on clk_in; pins asynchronous
`timescale 1ns/100ps
`include "apc_defines.svh"
module apc_port #(
	parameter int PINS = 8
) (
	input  wire logic                   clk_in,
	input  wire logic                   arst_n_in,
	input  wire logic [`APC_ADDR_W-1:0] addr_in,
	input  wire logic [7:0]             wdata_in,
	input  wire logic                   wr_in,
	input  wire logic                   rd_in,
	output logic      [7:0]             rdata_out,
	input  wire logic [PINS-1:0]        pin_in,
	output logic      [PINS-1:0]        pin_out,
	output logic      [PINS-1:0]        pin_oe_out,
	output logic      [PINS-1:0]        pad_weak_out,
	output logic      [PINS-1:0]        pad_pull_up_out,
	output logic      [PINS-1:0]        pad_pull_down_out,
	input  wire logic [PINS-1:0]        converter_channel_en_in,
	input  wire logic [PINS-1:0]        periph_own_in,
	input  wire logic [PINS-1:0]        periph_oe_in,
	input  wire logic [PINS-1:0]        periph_data_in,
	output logic      [PINS-1:0]        periph_pin_out
);
	// Stored registers and the synchronised pin levels
	logic [PINS-1:0] port_output_latch;
	logic [PINS-1:0] pin_direction_select;
	logic [PINS-1:0] drive_weaken_select;
	logic [PINS-1:0] pull_device_enable;
	logic [PINS-1:0] pull_polarity_select;
	logic [PINS-1:0] pin_level_snapshot;
	logic [PINS-1:0] next_rdata;
	apc_pkg::apc_sel_t sel;

	// Address decode into one-hot selection
	function automatic apc_pkg::apc_sel_t decode(
		input logic [`APC_ADDR_W-1:0] a
	);
		case (a)
			`APC_OFF_DATA:      decode = apc_pkg::APC_SEL_DATA;
			`APC_OFF_SNAPSHOT:  decode = apc_pkg::APC_SEL_SNAPSHOT;
			`APC_OFF_DIRECTION: decode = apc_pkg::APC_SEL_DIRECTION;
			`APC_OFF_WEAKEN:    decode = apc_pkg::APC_SEL_WEAKEN;
			`APC_OFF_PULL_EN:   decode = apc_pkg::APC_SEL_PULL;
			default:            decode = apc_pkg::APC_SEL_NONE;
		endcase
	endfunction

	// Per pin, take a where the mask is set and b elsewhere
	function automatic logic [PINS-1:0] pick(
		input logic [PINS-1:0] mask,
		input logic [PINS-1:0] a,
		input logic [PINS-1:0] b
	);
		pick = (mask & a) | (~mask & b);
	endfunction

	// Pin levels pass two flops before any use
	apc_sync #(
		.WIDTH (PINS)
	) u_sync (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.async_in  (pin_in),
		.sync_out  (pin_level_snapshot)
	);

	// Selection of the addressed register
	assign sel = decode(addr_in);

	// Polarity sits outside the one-hot code
	wire pol_hit = (addr_in == `APC_OFF_POLARITY);

	// Write enables; the snapshot address has none
	wire wr_latch     = wr_in && (sel == apc_pkg::APC_SEL_DATA);
	wire wr_direction = wr_in && (sel == apc_pkg::APC_SEL_DIRECTION);
	wire wr_weaken    = wr_in && (sel == apc_pkg::APC_SEL_WEAKEN);
	wire wr_pull_en   = wr_in && (sel == apc_pkg::APC_SEL_PULL);
	wire wr_polarity  = wr_in && pol_hit;

	// Write data trimmed to the pin count
	wire [PINS-1:0] wr_bits = wdata_in[PINS-1:0];

	// Next values: store any write, hold otherwise
	wire [PINS-1:0] next_latch     = wr_latch
		? wr_bits : port_output_latch;
	wire [PINS-1:0] next_direction = wr_direction
		? wr_bits : pin_direction_select;
	wire [PINS-1:0] next_weaken    = wr_weaken
		? wr_bits : drive_weaken_select;
	wire [PINS-1:0] next_pull_en   = wr_pull_en
		? wr_bits : pull_device_enable;
	wire [PINS-1:0] next_polarity  = wr_polarity
		? wr_bits : pull_polarity_select;

	// Output latch, driven only on output pins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			port_output_latch <= `APC_RST_REG;
		else
			port_output_latch <= next_latch;
	end

	// Direction bits, all inputs out of reset
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pin_direction_select <= `APC_RST_REG;
		else
			pin_direction_select <= next_direction;
	end

	// Weak drive bits, full drive out of reset
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			drive_weaken_select <= `APC_RST_REG;
		else
			drive_weaken_select <= next_weaken;
	end

	// Pull enable bits, no pull out of reset
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pull_device_enable <= `APC_RST_REG;
		else
			pull_device_enable <= next_pull_en;
	end

	// Polarity bits, pull-up chosen out of reset
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pull_polarity_select <= `APC_RST_REG;
		else
			pull_polarity_select <= next_polarity;
	end

	// Peripheral ownership overrides the direction bit
	wire [PINS-1:0] own_periph = periph_own_in;
	wire [PINS-1:0] is_output  = pick(own_periph, periph_oe_in,
		pin_direction_select);
	// Input wherever nothing drives
	wire [PINS-1:0] is_input   = ~is_output;
	// Pull allowed only on inputs with the channel off
	wire [PINS-1:0] pull_on    = pull_device_enable & is_input
		& ~converter_channel_en_in;

	// Pad enable and value, peripheral or latch
	assign pin_oe_out = is_output;
	assign pin_out    = pick(own_periph, periph_data_in,
		port_output_latch);

	// Weak drive only reaches output pins
	assign pad_weak_out = drive_weaken_select
		& is_output;

	// Polarity steers the permitted pull
	assign pad_pull_up_out   = pull_on
		& ~pull_polarity_select;
	assign pad_pull_down_out = pull_on
		& pull_polarity_select;

	// Peripherals see the synchronised level
	assign periph_pin_out = pin_level_snapshot;

	// Data readback: latch where the direction bit is set, pin level elsewhere
	wire [PINS-1:0] data_view  = pick(pin_direction_select,
		port_output_latch, pin_level_snapshot);
	// Polarity read, zero for unmapped addresses
	wire [PINS-1:0] other_view = pol_hit ? pull_polarity_select : '0;

	// Read data selection
	always_comb
	begin
		case (sel)
			apc_pkg::APC_SEL_DATA:      next_rdata = data_view;
			apc_pkg::APC_SEL_SNAPSHOT:  next_rdata = pin_level_snapshot;
			apc_pkg::APC_SEL_DIRECTION: next_rdata = pin_direction_select;
			apc_pkg::APC_SEL_WEAKEN:    next_rdata = drive_weaken_select;
			apc_pkg::APC_SEL_PULL:      next_rdata = pull_device_enable;
			default:                    next_rdata = other_view;
		endcase
	end

	// Read data one cycle after strobe, zero otherwise
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rdata_out <= 8'h00;
		else if (rd_in)
			rdata_out <= 8'(next_rdata);
		else
			rdata_out <= 8'h00;
	end
endmodule

// *** rtl/apc_defines.svh ***
// Register offsets, reset values and timing counts for the analog port
// Assumes inclusion by bare name from rtl files
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH
`define APC_ADDR_W          8
`define APC_OFF_DATA        8'h30
`define APC_OFF_SNAPSHOT    8'h31
`define APC_OFF_DIRECTION   8'h32
`define APC_OFF_WEAKEN      8'h33
`define APC_OFF_PULL_EN     8'h34
`define APC_OFF_POLARITY    8'h35
`define APC_RST_REG         8'h00
`define APC_SYNC_STAGES     2
`define APC_POL_PULL_UP     1'b0
`define APC_POL_PULL_DOWN   1'b1
`endif

// *** rtl/apc_pkg.sv ***
// Types for the analog port pin control block
// Assumes no other package
package apc_pkg;
	typedef enum logic [5:0] {
		APC_SEL_NONE      = 6'h01,
		APC_SEL_DATA      = 6'h02,
		APC_SEL_SNAPSHOT  = 6'h04,
		APC_SEL_DIRECTION = 6'h08,
		APC_SEL_WEAKEN    = 6'h10,
		APC_SEL_PULL      = 6'h20
	} apc_sel_t;
endpackage

// *** rtl/apc_sync.sv ***
// Two-stage synchroniser for a bus of pin levels
// Assumes inputs are asynchronous to clk_in
`timescale 1ns/100ps
module apc_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             arst_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			stage_one <= '0;
			sync_out  <= '0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule

// *** sim/apc_port_properties.sv ***
// Checker for pad gating and read timing of the analog port
// Assumes bound to apc_port, one clock domain
`timescale 1ns/100ps
module apc_port_properties (
	input wire logic       clk_in,
	input wire logic       arst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_oe_out,
	input wire logic [7:0] pad_weak_out,
	input wire logic [7:0] pad_pull_up_out,
	input wire logic [7:0] pad_pull_down_out,
	input wire logic [7:0] converter_channel_en_in,
	input wire logic [7:0] periph_own_in,
	input wire logic [7:0] periph_oe_in,
	input wire logic [7:0] periph_pin_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// Snapshot read request
	sequence s_snap;
		rd_in && addr_in == 8'h31;
	endsequence
	a_pull_gate:
	assert property (((pad_pull_up_out | pad_pull_down_out) & (pin_oe_out
		| converter_channel_en_in)) == 8'h00) else $error("pull not gated");
	a_pull_excl:
	assert property ((pad_pull_up_out & pad_pull_down_out) == 8'h00)
		else $error("pull up and down");
	a_weak_gate:
	assert property ((pad_weak_out & ~pin_oe_out) == 8'h00)
		else $error("weak on input");
	a_own_oe:
	assert property (((pin_oe_out ^ periph_oe_in) & periph_own_in) == 8'h00)
		else $error("owned pin enable");
	a_rd_idle:
	assert property (!rd_in |=> rdata_out == 8'h00) else $error("stray data");
	a_sync_lag:
	assert property ($past(arst_n_in, 2) |-> periph_pin_out == $past(pin_in, 2))
		else $error("sync lag");
	a_pull_reset:
	assert property ($rose(arst_n_in) |-> (pad_pull_up_out | pad_pull_down_out)
		== 8'h00) else $error("pull after reset");
	a_snap_read:
	assert property (s_snap |=> rdata_out == $past(periph_pin_out))
		else $error("snapshot read");
endmodule
bind apc_port apc_port_properties i_apc_port_properties (.*);

// *** sim/apc_board.sv ***
// Board model: pin level from the pad or from the board
// Assumes pad enable high while the port drives
`timescale 1ns/100ps
module apc_board (
	input  wire logic [7:0] pad_in,
	input  wire logic [7:0] oe_in,
	input  wire logic [7:0] board_in,
	output logic      [7:0] lvl_out
);
	// Pad wins where it drives
	assign lvl_out = (oe_in & pad_in) | (~oe_in & board_in);
endmodule

// *** sim/test_analog_port_pin_control.sv ***
// Bench: random register and pin traffic with model compare
// Assumes apc_port, apc_board and the checker bind
`timescale 1ns/100ps
module test_analog_port_pin_control;
	logic        clk_in = 1'b0, arst_n_in = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0]  addr = 8'h00, wd = 8'h00, own = 8'h00, poe = 8'h00;
	logic [7:0]  pdat = 8'h00, conv = 8'h00, ext = 8'h00, rdat, po, oe;
	logic [7:0]  wk, pu, pd, ppo, lvl, r [8] = '{default: 8'h00};
	logic [31:0] s = 32'h186c;
	int          errors = 0, cmp_count = 0, cyc = 0;
	initial forever #5 clk_in = ~clk_in;
	apc_port i_apc_port (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdat), .pin_in(lvl), .pin_out(po), .pin_oe_out(oe),
		.pad_weak_out(wk), .pad_pull_up_out(pu), .pad_pull_down_out(pd),
		.converter_channel_en_in(conv), .periph_own_in(own),
		.periph_oe_in(poe), .periph_data_in(pdat), .periph_pin_out(ppo));
	apc_board i_apc_board (.pad_in(po), .oe_in(oe), .board_in(ext),
		.lvl_out(lvl));
	// Expected enables, pin level and read data
	function automatic logic [7:0] x_oe(); return (own & poe) | (~own & r[2]);
	endfunction
	function automatic logic [7:0] x_lvl();
		return (x_oe() & ((own & pdat) | (~own & r[0]))) | (~x_oe() & ext);
	endfunction
	function automatic logic [7:0] x_rd(input int a);
		return a == 0 ? (r[2] & r[0]) | (~r[2] & x_lvl()) : a == 1 ? x_lvl() : r[a];
	endfunction
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h80200003 : 32'h00000000);
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// One strobe cycle, write or read
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge clk_in);
		{addr, wd, wr, rd} <= {a, d, w, ~w};
		@(posedge clk_in);
		{wr, rd} <= 2'b00;
	endtask
	task automatic print_verdict();
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Cycle ceiling against hangs
	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			errors++;
			print_verdict();
		end
	end
	// Reset, then random writes, pin traffic and reads
	initial
	begin
		repeat (10) @(posedge clk_in);
		arst_n_in <= 1'b1;
		#1 check(pu | pd, 8'h00);
		for (int i = 0; i < 60; i++)
		begin
			s = lfsr(s);
			acc(8'h30 + s[2:0], s[15:8], 1'b1);
			if (s[2:0] < 6 && s[2:0] != 1) r[s[2:0]] = s[15:8];
			{own, conv} <= s[31:16];
			s = lfsr(s);
			{poe, pdat, ext} <= s[23:0];
			repeat (3) @(posedge clk_in);
			#1 check(oe, x_oe());
			check(po, (own & pdat) | (~own & r[0]));
			check(wk, r[3] & x_oe());
			check(pu, r[4] & ~x_oe() & ~conv & ~r[5]);
			check(pd, r[4] & ~x_oe() & ~conv & r[5]);
			check(ppo, x_lvl());
			acc(8'h30 + s[26:24], 8'h00, 1'b0);
			#1 check(rdat, x_rd(s[26:24]));
		end
		print_verdict();
	end
endmodule
